/* File: twcp_pkg.sv */
// package for the three-wire configuration port with readback
// assumes a single system clock; serial pins are asynchronous to it
package twcp_pkg;

  // word geometry
  localparam int unsigned TWCP_WORD_W = 32;
  localparam int unsigned TWCP_CNT_W = 6;
  localparam logic [5:0] TWCP_WORD_BITS = 6'h20;
  localparam logic [5:0] TWCP_BIT_LAST = 6'h1F;

  // address field positions
  localparam int unsigned TWCP_REG_LSB = 0;
  localparam int unsigned TWCP_BANK_LSB = 3;
  localparam int unsigned TWCP_ID_LSB = 5;
  localparam int unsigned TWCP_CMD_REG_LSB = 27;
  localparam int unsigned TWCP_RB_FLAG_BIT = 31;

  // register numbers, main bank number and version code
  localparam logic [2:0] TWCP_REG_STATUS = 3'h0;
  localparam logic [2:0] TWCP_REG_SETUP1 = 3'h1;
  localparam logic [2:0] TWCP_REG_SETUP2 = 3'h2;
  localparam logic [2:0] TWCP_REG_SETUP3 = 3'h3;
  localparam logic [2:0] TWCP_REG_UNUSED = 3'h4;
  localparam logic [2:0] TWCP_REG_SETUP5 = 3'h5;
  localparam logic [1:0] TWCP_BANK_MAIN = 2'h1;
  localparam logic [1:0] TWCP_VERSION = 2'h1;

  // bits of the offset calibration setup word
  localparam int unsigned TWCP_AUTOCAL_BIT = 5;

  // values after reset
  localparam logic [31:0] TWCP_RST_SETUP1 = 32'h01005589;
  localparam logic [31:0] TWCP_RST_SETUP2 = 32'h31E0200A;
  localparam logic [31:0] TWCP_RST_SETUP3 = 32'h4000000B;
  localparam logic [31:0] TWCP_RST_SETUP5 = 32'h0000AAAD;

  // link signals after synchronisation
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic latch_strobe_alias;
  } twcp_link_s;

  // readback shifter states
  typedef enum logic [2:0] {
    TWCP_RB_IDLE = 3'b001,
    TWCP_RB_ARMED = 3'b010,
    TWCP_RB_SHIFT = 3'b100
  } twcp_rb_e;

endpackage

/* File: twcp_sync.sv */
// two-flop synchroniser for the serial pins
// assumes inputs are asynchronous to clk_sys_i
`timescale 1ns/1ps
module twcp_sync
  import twcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // raw pins
  input wire twcp_link_s pins_i,
  // synchronised copy
  output twcp_link_s sync_o
);

  typedef struct packed {
    twcp_link_s meta;
    twcp_link_s sync;
  } twcp_sync_s;

  twcp_sync_s st_ff;
  twcp_sync_s nxt_st;

  // first stage only feeds the second stage
  always_comb
  begin
    nxt_st.meta = pins_i;
    nxt_st.sync = st_ff.meta;
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.sync;

endmodule

/* File: twcp_port.sv */
// three-wire serial configuration port with register readback
// assumes each serial clock phase lasts at least two clk_sys_i cycles,
// so the pins are seen through the two-flop synchroniser (bench: 100 ns)
// assumes autocal_done_i and the dac values come from the clk_sys_i domain
`timescale 1ns/1ps
// Operation
// - 32-bit shift register collects each word
// - data sampled on serial clock rise, LSB first
// - strobe rise loads addressed register
// - bits 0-2 register, bits 3-4 bank
// - writes to register four ignored
// - setup registers and dac status readable
// - readback: write phase then read phase
// - command word selects readback register
// - next bit driven on each clock rise
// - one idle clock, then 32 bits
// - status word: address, then version code
module twcp_port
  import twcp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic latch_strobe_alias_i,
  output logic readback_o,
  // calibration engine status
  input wire logic [7:0] dac_i_i,
  input wire logic [7:0] dac_q_i,
  input wire logic autocal_done_i,
  // configuration words to the analog core
  output logic [31:0] device_setup_primary_o,
  output logic [31:0] offset_calibration_setup_o,
  output logic [31:0] mixer_load_filter_setup_o,
  output logic [31:0] bias_trim_setup_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic sclk_d;
    logic strobe_d;
    logic [31:0] shift;
    logic [31:0] setup1;
    logic [31:0] setup2;
    logic [31:0] setup3;
    logic [31:0] setup5;
    logic rb_req;
    logic [2:0] rb_sel;
    twcp_rb_e rb_state;
    logic [31:0] rb_word;
    logic [5:0] rb_cnt;
    logic rb_out;
  } twcp_state_s;

  twcp_state_s st_ff;
  twcp_state_s nxt_st;
  twcp_link_s pins;
  twcp_link_s link;
  logic sclk_rise;
  logic strobe_rise;
  logic [31:0] status_word;
  logic [3:0] wr_hit; // setup word targeted by the shifter
  logic rb_cmd; // shifter holds a readback command

  // ==========================================================
  // pin synchronisation
  assign pins.sclk = sclk_i;
  assign pins.sdata = sdata_i;
  assign pins.latch_strobe_alias = latch_strobe_alias_i;

  twcp_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pins_i(pins),
    .sync_o(link)
  );

  // edge detection on the synchronised pins
  assign sclk_rise = link.sclk & ~st_ff.sclk_d;
  assign strobe_rise = link.latch_strobe_alias & ~st_ff.strobe_d;

  // ==========================================================
  // functions
  // address field that each register reports in its low bits
  function automatic logic [4:0] addr_field(input logic [2:0] reg_no);
    addr_field = {TWCP_BANK_MAIN, reg_no};
  endfunction

  // one-hot decode of a register number onto the four setup words:
  // bit 0 setup1, bit 1 setup2, bit 2 setup3, bit 3 setup5
  function automatic logic [3:0] setup_hit(input logic [2:0] reg_no);
    logic [3:0] hit;
    hit = 4'h0;
    if (reg_no == TWCP_REG_SETUP1)
    begin
      hit = 4'h1;
    end
    else if (reg_no == TWCP_REG_SETUP2)
    begin
      hit = 4'h2;
    end
    else if (reg_no == TWCP_REG_SETUP3)
    begin
      hit = 4'h4;
    end
    else if (reg_no == TWCP_REG_SETUP5)
    begin
      hit = 4'h8;
    end
    else if (reg_no == TWCP_REG_UNUSED)
    begin
      hit = 4'h0; // register four has no storage
    end
    setup_hit = hit;
  endfunction

  // a readback command carries the flag bit and the status number
  function automatic logic is_rb_cmd(input logic [31:0] word);
    is_rb_cmd = word[TWCP_RB_FLAG_BIT] && (word[2:0] == TWCP_REG_STATUS);
  endfunction

  // word picked for readback; any number without storage returns the
  // status word, so a stray select never shifts out stale data
  function automatic logic [31:0] rb_pick(input twcp_state_s s, input logic [31:0] stat);
    logic [3:0] hit;
    logic [31:0] w;
    hit = setup_hit(s.rb_sel);
    w = stat;
    if (hit[0])
    begin
      w = s.setup1;
    end
    else if (hit[1])
    begin
      w = s.setup2;
    end
    else if (hit[2])
    begin
      w = s.setup3;
    end
    else if (hit[3])
    begin
      w = s.setup5;
    end
    rb_pick = w;
  endfunction

  // decode of the word waiting in the shifter
  assign wr_hit = setup_hit(st_ff.shift[2:0]);
  assign rb_cmd = is_rb_cmd(st_ff.shift);

  // status word: address, version, q dac, i dac
  always_comb
  begin
    status_word = '0;
    status_word[4:0] = addr_field(TWCP_REG_STATUS);
    status_word[TWCP_ID_LSB +: 2] = TWCP_VERSION;
    status_word[23:16] = dac_q_i;
    status_word[31:24] = dac_i_i;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_st = st_ff;
    // edge detector history follows the synchronised pins
    nxt_st.sclk_d = link.sclk;
    nxt_st.strobe_d = link.latch_strobe_alias;

    // shift in on serial clock rise, lsb first; the shifter keeps running
    // during readback as well, harmless since only a strobe rise reads it
    if (sclk_rise)
    begin
      nxt_st.shift = {link.sdata, st_ff.shift[31:1]};
    end

    // autocal bit clears itself once calibration finishes; it comes before
    // the strobe decode so that a host write in the same cycle wins
    if (autocal_done_i)
    begin
      nxt_st.setup2[TWCP_AUTOCAL_BIT] = 1'b0;
    end

    // latch on strobe rise: either a readback command or a setup word
    if (strobe_rise)
    begin
      nxt_st.rb_req = 1'b0;
      if (rb_cmd)
      begin
        // readback command word
        nxt_st.rb_req = 1'b1;
        nxt_st.rb_sel = st_ff.shift[TWCP_CMD_REG_LSB +: 3];
      end
      else if (wr_hit[0])
      begin
        nxt_st.setup1 = st_ff.shift;
      end
      else if (wr_hit[1])
      begin
        nxt_st.setup2 = st_ff.shift;
      end
      else if (wr_hit[2])
      begin
        nxt_st.setup3 = st_ff.shift;
      end
      else if (wr_hit[3])
      begin
        nxt_st.setup5 = st_ff.shift;
      end
      // register four and unknown numbers are dropped
    end

    // readback shifter: idle waits for a command strobe, armed lets the
    // idle clock pass and freezes the word, shift sends it out lsb first
    case (st_ff.rb_state)
      TWCP_RB_IDLE:
      begin
        if (strobe_rise && nxt_st.rb_req)
        begin
          nxt_st.rb_state = TWCP_RB_ARMED;
        end
      end
      TWCP_RB_ARMED:
      begin
        // first clock after the strobe is idle
        if (sclk_rise)
        begin
          nxt_st.rb_word = rb_pick(st_ff, status_word);
          nxt_st.rb_cnt = '0;
          nxt_st.rb_state = TWCP_RB_SHIFT;
        end
      end
      TWCP_RB_SHIFT:
      begin
        // launch on rise so the host can take it on the fall
        if (sclk_rise)
        begin
          nxt_st.rb_out = st_ff.rb_word[0];
          nxt_st.rb_word = {1'b0, st_ff.rb_word[31:1]};
          nxt_st.rb_cnt = st_ff.rb_cnt + 6'h01;
          if (st_ff.rb_cnt == TWCP_BIT_LAST)
          begin
            nxt_st.rb_state = TWCP_RB_IDLE;
            nxt_st.rb_req = 1'b0;
          end
        end
      end
      default:
      begin
        nxt_st.rb_state = TWCP_RB_IDLE;
      end
    endcase
    // a new strobe in mid-sequence aborts it; a command word starts over
    // with the new selection, anything else leaves the shifter idle
    if (strobe_rise && st_ff.rb_state != TWCP_RB_IDLE)
    begin
      nxt_st.rb_state = nxt_st.rb_req ? TWCP_RB_ARMED : TWCP_RB_IDLE;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // setup words start at their power-on values, the readback side idle;
      // edge history starts low to match the idle level of the pins
      st_ff <= '{
        sclk_d: 1'b0,
        strobe_d: 1'b0,
        shift: '0,
        setup1: TWCP_RST_SETUP1,
        setup2: TWCP_RST_SETUP2,
        setup3: TWCP_RST_SETUP3,
        setup5: TWCP_RST_SETUP5,
        rb_req: 1'b0,
        rb_sel: '0,
        rb_state: TWCP_RB_IDLE,
        rb_word: '0,
        rb_cnt: '0,
        rb_out: 1'b0
      };
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign readback_o = st_ff.rb_out;
  assign device_setup_primary_o = st_ff.setup1;
  assign offset_calibration_setup_o = st_ff.setup2;
  assign mixer_load_filter_setup_o = st_ff.setup3;
  assign bias_trim_setup_o = st_ff.setup5;

endmodule

/* File: twcp_port_sva.sv */
// checker for the serial configuration port
// assumes pins change away from the rising clock edge
`timescale 1ns/1ps
module twcp_port_sva
  import twcp_pkg::*;
(
  // watched ports
  input logic clk_sys_i,
  input logic rst_i,
  input logic sclk_i,
  input logic latch_strobe_alias_i,
  input logic autocal_done_i,
  input logic readback_o,
  input logic [31:0] device_setup_primary_o,
  input logic [31:0] offset_calibration_setup_o,
  input logic [31:0] mixer_load_filter_setup_o,
  input logic [31:0] bias_trim_setup_o
);
  logic [2:0] st_age_ff;
  logic [2:0] sc_age_ff;
  logic [1:0] rises_ff;
  // ====
  // ages of pin rises, clock rises since strobe
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_age_ff <= 3'h7;
      sc_age_ff <= 3'h7;
      rises_ff <= 2'h0;
    end
    else
    begin
      st_age_ff <= $rose(latch_strobe_alias_i) ? 3'h0 : st_age_ff + 3'(st_age_ff != 3'h7);
      sc_age_ff <= $rose(sclk_i) ? 3'h0 : sc_age_ff + 3'(sc_age_ff != 3'h7);
      rises_ff <= $rose(latch_strobe_alias_i) ? 2'h0
        : rises_ff + 2'($rose(sclk_i) && rises_ff != 2'h3);
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence strobe_recent;
    st_age_ff inside {[3'h1:3'h5]};
  endsequence
  sequence cal_cleared;
    ##[1:3] !offset_calibration_setup_o[TWCP_AUTOCAL_BIT];
  endsequence
  reset_state_a: assert property (
    $fell(rst_i) |-> !readback_o && bias_trim_setup_o == TWCP_RST_SETUP5)
    else $error("bad state after reset");
  cfg_source_a: assert property (
    $changed({device_setup_primary_o, mixer_load_filter_setup_o, bias_trim_setup_o})
    |-> strobe_recent) else $error("setup moved without strobe");
  cal_source_a: assert property (
    $changed(offset_calibration_setup_o)
    |-> st_age_ff <= 3'h5 || $past(autocal_done_i) || $past(autocal_done_i, 2))
    else $error("cal setup moved without cause");
  one_target_a: assert property (
    $onehot0({$changed(device_setup_primary_o), $changed(offset_calibration_setup_o),
    $changed(mixer_load_filter_setup_o), $changed(bias_trim_setup_o)}))
    else $error("several setups moved");
  addr_field_a: assert property (
    {device_setup_primary_o[2:0], offset_calibration_setup_o[2:0],
    mixer_load_filter_setup_o[2:0], bias_trim_setup_o[2:0]} == {TWCP_REG_SETUP1,
    TWCP_REG_SETUP2, TWCP_REG_SETUP3, TWCP_REG_SETUP5}) else $error("wrong target");
  cal_clear_a: assert property (
    autocal_done_i |-> cal_cleared) else $error("autocal bit not cleared");
  rb_launch_a: assert property (
    $changed(readback_o) |-> sc_age_ff inside {[3'h1:3'h5]})
    else $error("readback moved off clock");
  idle_clock_a: assert property (
    $changed(readback_o) |-> rises_ff != 2'h1) else $error("idle clock launched");
endmodule
bind twcp_port twcp_port_sva u_sva (.clk_sys_i, .rst_i, .sclk_i, .latch_strobe_alias_i,
  .autocal_done_i, .readback_o, .device_setup_primary_o, .offset_calibration_setup_o,
  .mixer_load_filter_setup_o, .bias_trim_setup_o);

/* File: twcp_host.sv */
// host model driving the three serial pins
// assumes a 25 ns bench clock; half a serial period is 4 cycles
`timescale 1ns/1ps
module twcp_host
(
  // bench clock
  input logic clk_i,
  // serial pins
  output logic sclk_o = 1'b0,
  output logic sdata_o = 1'b0,
  output logic strobe_o = 1'b0,
  input logic readback_i
);
  // ====
  // half a serial clock period
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  // shift a word lsb first, then pulse the strobe once
  task automatic put(input logic [31:0] w);
    for (int i = 0; i < 32; i++)
    begin
      sdata_o = w[i];
      half();
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
    end
    sdata_o = ~sdata_o; // released line shows no stale bit
    strobe_o = 1'b1;
    half();
    strobe_o = 1'b0;
    half();
  endtask
  // command word, one idle clock, then 32 bits taken at falling edges
  task automatic get(input logic [31:0] cmd, output logic [31:0] r);
    put(cmd);
    for (int i = -1; i < 32; i++)
    begin
      sclk_o = 1'b1;
      half();
      if (i >= 0) r[i] = readback_i;
      sclk_o = 1'b0;
      half();
    end
  endtask
endmodule

/* File: tb_three_wire_config_port_readback.sv */
// bench for the serial configuration port with readback
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_three_wire_config_port_readback
  import twcp_pkg::*;
;
  logic clk_sys_i;
  logic rst_i = 1'b1;
  logic autocal_done_i = 1'b0;
  logic [7:0] dac_i_i = 8'h00;
  logic [7:0] dac_q_i = 8'h00;
  logic sclk, sdata, strobe, readback_o;
  logic [31:0] s1, s2, s3, s5, w, rd_w;
  logic [31:0] vals [8];
  logic [31:0] moved;
  logic [127:0] last;
  logic [31:0] exp_q [$];
  int err_count = 0;
  int checked = 0;
  int seed = 8351;
  event rd_ev;
  twcp_port uut (.clk_sys_i, .rst_i, .sclk_i(sclk), .sdata_i(sdata),
    .latch_strobe_alias_i(strobe), .readback_o, .dac_i_i, .dac_q_i, .autocal_done_i,
    .device_setup_primary_o(s1), .offset_calibration_setup_o(s2),
    .mixer_load_filter_setup_o(s3), .bias_trim_setup_o(s5));
  twcp_host host (.clk_i(clk_sys_i), .sclk_o(sclk), .sdata_o(sdata), .strobe_o(strobe),
    .readback_i(readback_o));
  // ====
  // system clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a setup word that moves takes the oldest note
  always @(negedge clk_sys_i)
  begin
    if (!rst_i && last !== {s1, s2, s3, s5})
    begin
      moved = last[127:96] !== s1 ? s1 : last[95:64] !== s2 ? s2
        : last[63:32] !== s3 ? s3 : s5;
      chk(moved, exp_q.pop_front());
    end
    last <= {s1, s2, s3, s5};
  end
  // a finished readback takes the oldest note
  always @(rd_ev)
    chk(rd_w, exp_q.pop_front());
  // reset, writes to registers 1 to 7, readbacks, autocal clear
  initial
  begin
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(s1, TWCP_RST_SETUP1);
    chk(s2, TWCP_RST_SETUP2);
    chk(s3, TWCP_RST_SETUP3);
    chk(s5, TWCP_RST_SETUP5);
    {dac_i_i, dac_q_i} = 16'($random(seed));
    // numbers 4, 6 and 7 have no storage: nothing may move for them
    for (int r = 1; r < 8; r++)
    begin
      w = $random(seed);
      w[2:0] = 3'(r);
      w[5] = w[5] && r != 2;
      vals[r] = w;
      if (r inside {1, 2, 3, 5}) exp_q.push_back(w);
      host.put(w);
    end
    for (int r = 0; r < 8; r++)
    begin
      exp_q.push_back(r inside {1, 2, 3, 5} ? vals[r]
        : {dac_i_i, dac_q_i, 9'h000, TWCP_VERSION, TWCP_BANK_MAIN, TWCP_REG_STATUS});
      host.get({2'h2, 3'(r), 27'h0000000}, rd_w);
      -> rd_ev;
    end
    w = vals[2];
    w[TWCP_AUTOCAL_BIT] = 1'b1;
    exp_q.push_back(w);
    host.put(w);
    w[TWCP_AUTOCAL_BIT] = 1'b0;
    exp_q.push_back(w);
    autocal_done_i = 1'b1;
    @(negedge clk_sys_i);
    autocal_done_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    chk(32'(exp_q.size()), 32'h00000000);
    give_verdict();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #500000;
    err_count++;
    give_verdict();
  end
endmodule
